// [design/hrcp_fifo.sv]
// Read data FIFO module is defined beside the controller in hrcp_host.sv

// [design/hrcp_host.sv]
// Host-side read cycle controller driving the device's asynchronous read port, with its read data FIFO
// Summary of operation
// - Wait 165ns after data/status queue reads before fill level; 330ns between discard reads.
// - After skip-ahead completes, wait 330ns after datapath control before status queue reads.
// - Spacing may be met by dummy test reads or elapsed time; elapsed time used.
// - Cycle starts when select and strobe both low, ends when either rises.
// - Host raises select and strobe high for the deassertion time between reads.
// - Burst of up to 16 words by changing address; strobes high between bursts.
// - Queue-port select is driven like an address line, but held unchanged while the address steps through a burst.
// - Data bus is 16 bits wide in every read mode.
`timescale 1ns/1ps
// ****************************************
// Read data FIFO
// ****************************************
module hrcp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
        logic valid;
        logic [WIDTH-1:0] head;
    } hrcp_fifo_state_type;
    hrcp_fifo_state_type s_q, s_d;
    logic push, pop;
    always_comb begin
        s_d = s_q;
        push = i_in_valid && (s_q.cnt != (AW+1)'(DEPTH));
        pop = i_out_ready && (s_q.cnt != '0);
        if (push) begin
            s_d.mem[s_q.wr] = i_in_data;
            s_d.wr = (s_q.wr == AW'(DEPTH - 1)) ? '0 : s_q.wr + 1'b1;
        end
        if (pop) begin
            s_d.rd = (s_q.rd == AW'(DEPTH - 1)) ? '0 : s_q.rd + 1'b1;
        end
        if (push && !pop) begin
            s_d.cnt = s_q.cnt + 1'b1;
        end else if (pop && !push) begin
            s_d.cnt = s_q.cnt - 1'b1;
        end
        // Outputs registered from the next state
        s_d.valid = (s_d.cnt != '0);
        s_d.head = s_d.mem[s_d.rd];
    end
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign o_in_ready = (s_q.cnt != (AW+1)'(DEPTH));
    assign o_out_valid = s_q.valid;
    assign o_out_data = s_q.head;
endmodule : hrcp_fifo

module hrcp_host #(
    parameter int DATA_W = hrcp_pkg::DATA_W,
    parameter int ADDR_W = hrcp_pkg::ADDR_W,
    parameter int FIFO_DEPTH = 8
) (
    input wire logic i_clk,
    input wire logic i_reset,
    // Command port
    input wire logic i_cmd_valid,
    output logic o_cmd_ready,
    input wire logic [ADDR_W-1:0] i_cmd_addr,
    input wire logic [4:0] i_cmd_len,
    input wire logic i_cmd_queue_sel,
    input wire hrcp_pkg::hrcp_res_type i_cmd_res,
    input wire logic i_cmd_after_skip,
    // Read data stream
    output logic o_rd_valid,
    input wire logic i_rd_ready,
    output logic [DATA_W-1:0] o_rd_data,
    // Device pins
    output logic o_chip_select_n,
    output logic o_read_strobe_n,
    output logic [ADDR_W-1:0] o_addr,
    output logic o_queue_sel,
    input wire logic [DATA_W-1:0] i_data
);
    typedef struct packed {
        hrcp_pkg::hrcp_state_type st;
        logic [hrcp_pkg::CNT_W-1:0] cnt;
        logic [hrcp_pkg::CNT_W-1:0] gap;
        logic [4:0] left;
        hrcp_pkg::hrcp_res_type last_res;
        hrcp_pkg::hrcp_res_type res;
        logic after_skip;
        logic cs_n;
        logic rd_n;
        logic [ADDR_W-1:0] addr;
        logic qsel;
        logic push;
        logic ready;
        logic [DATA_W-1:0] data;
    } hrcp_host_state_type;
    hrcp_host_state_type s_q, s_d;
    logic fifo_in_ready;
    logic need_long;
    logic need_short;
    logic [hrcp_pkg::CNT_W-1:0] need;

    // ****************************************
    // Spacing required before the pending read
    // ****************************************
    always_comb begin
        need_short = ((s_q.last_res == hrcp_pkg::HRCP_RES_RX_DATA ||
            s_q.last_res == hrcp_pkg::HRCP_RES_RX_STATUS) && s_q.res == hrcp_pkg::HRCP_RES_RX_FILL) ||
            (s_q.last_res == hrcp_pkg::HRCP_RES_TX_STATUS && s_q.res == hrcp_pkg::HRCP_RES_TX_FILL);
        need_long = (s_q.last_res == hrcp_pkg::HRCP_RES_DISCARD && s_q.res == hrcp_pkg::HRCP_RES_DISCARD) ||
            (s_q.after_skip && s_q.last_res == hrcp_pkg::HRCP_RES_DP_CTRL &&
            (s_q.res == hrcp_pkg::HRCP_RES_RX_STATUS || s_q.res == hrcp_pkg::HRCP_RES_TX_STATUS));
        if (need_long) begin
            need = hrcp_pkg::CNT_W'(hrcp_pkg::CYC_GAP_LONG);
        end else if (need_short) begin
            need = hrcp_pkg::CNT_W'(hrcp_pkg::CYC_GAP_SHORT);
        end else begin
            need = hrcp_pkg::CNT_W'(hrcp_pkg::CYC_CSH);
        end
    end

    // ****************************************
    // Read cycle sequencer
    // ****************************************
    always_comb begin
        s_d = s_q;
        s_d.push = 1'b0;
        if (s_q.gap != {hrcp_pkg::CNT_W{1'b1}}) begin
            s_d.gap = s_q.gap + 1'b1;
        end
        case (s_q.st)
            hrcp_pkg::HRCP_IDLE: begin
                if (i_cmd_valid) begin
                    s_d.addr = i_cmd_addr;
                    s_d.qsel = i_cmd_queue_sel;
                    s_d.res = i_cmd_queue_sel ? hrcp_pkg::HRCP_RES_RX_DATA : i_cmd_res;
                    s_d.after_skip = i_cmd_after_skip;
                    s_d.left = (i_cmd_len == 5'h00) ? 5'h01 :
                        ((i_cmd_len > 5'(hrcp_pkg::BURST_MAX)) ? 5'(hrcp_pkg::BURST_MAX) : i_cmd_len);
                    s_d.st = hrcp_pkg::HRCP_WAIT;
                end
            end
            hrcp_pkg::HRCP_WAIT: begin
                if (s_q.gap >= need && fifo_in_ready) begin
                    s_d.cs_n = 1'b0;
                    s_d.rd_n = 1'b0;
                    // Burst first word also keeps the least address cycle
                    s_d.cnt = (s_q.left == 5'h01) ? '0 :
                        hrcp_pkg::CNT_W'(hrcp_pkg::CYC_CSL - hrcp_pkg::CYC_ACYC);
                    s_d.st = hrcp_pkg::HRCP_STROBE;
                end
            end
            hrcp_pkg::HRCP_STROBE: begin
                s_d.cnt = s_q.cnt + 1'b1;
                if (s_q.cnt == hrcp_pkg::CNT_W'(hrcp_pkg::CYC_CSL - 1) && fifo_in_ready) begin
                    s_d.data = i_data;
                    s_d.push = 1'b1;
                    s_d.left = s_q.left - 1'b1;
                    if (s_q.left == 5'h01) begin
                        s_d.cs_n = 1'b1;
                        s_d.rd_n = 1'b1;
                        s_d.last_res = s_q.res;
                        s_d.gap = '0;
                        s_d.st = hrcp_pkg::HRCP_RECOVER;
                    end else begin
                        // Burst: strobes held, next word address
                        s_d.addr = s_q.addr + 1'b1;
                        s_d.cnt = hrcp_pkg::CNT_W'(hrcp_pkg::CYC_CSL - hrcp_pkg::CYC_ACYC);
                    end
                end else if (s_q.cnt == hrcp_pkg::CNT_W'(hrcp_pkg::CYC_CSL - 1)) begin
                    s_d.cnt = s_q.cnt;
                end
            end
            hrcp_pkg::HRCP_RECOVER: begin
                if (s_q.gap >= hrcp_pkg::CNT_W'(hrcp_pkg::CYC_CYCLE - hrcp_pkg::CYC_CSL)) begin
                    s_d.st = hrcp_pkg::HRCP_IDLE;
                end
            end
            default: begin
                s_d.st = hrcp_pkg::HRCP_IDLE;
            end
        endcase
        s_d.ready = (s_d.st == hrcp_pkg::HRCP_IDLE);
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            s_q <= '0;
            s_q.ready <= 1'b1;
            s_q.cs_n <= 1'b1;
            s_q.rd_n <= 1'b1;
            s_q.gap <= {hrcp_pkg::CNT_W{1'b1}};
        end else begin
            s_q <= s_d;
        end
    end

    hrcp_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_in_valid(s_q.push),
        .o_in_ready(fifo_in_ready),
        .i_in_data(s_q.data),
        .o_out_valid(o_rd_valid),
        .i_out_ready(i_rd_ready),
        .o_out_data(o_rd_data)
    );

    assign o_cmd_ready = s_q.ready;
    assign o_chip_select_n = s_q.cs_n;
    assign o_read_strobe_n = s_q.rd_n;
    assign o_addr = s_q.addr;
    assign o_queue_sel = s_q.qsel;
endmodule : hrcp_host

// [design/hrcp_pkg.sv]
// Package of constants and types for the host read cycle port controller
package hrcp_pkg;
    localparam int CLK_PERIOD_PS = 5000;
    // Timing figures in ns as printed
    localparam int T_CYCLE_NS = 165;
    localparam int T_CSL_NS = 32;
    localparam int T_CSH_NS = 13;
    localparam int T_CSDV_NS = 30;
    localparam int T_ADV_NS = 40;
    localparam int T_ACYC_NS = 165;
    localparam int T_GAP_SHORT_NS = 165;
    localparam int T_GAP_LONG_NS = 330;
    // Least times rounded up to cycles
    localparam int CYC_CYCLE = (T_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CYC_CSL_RAW = (T_CSL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CYC_CSDV = (T_CSDV_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
    localparam int CYC_ADV = (T_ADV_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
    // Burst address period: address cycle time, never shorter than address to data
    localparam int CYC_ACYC_RAW = (T_ACYC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CYC_ACYC = (CYC_ACYC_RAW > CYC_ADV) ? CYC_ACYC_RAW : CYC_ADV;
    localparam int CYC_CSL = (CYC_CSL_RAW > CYC_CSDV) ? CYC_CSL_RAW : CYC_CSDV;
    localparam int CYC_CSH = (T_CSH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CYC_GAP_SHORT = (T_GAP_SHORT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CYC_GAP_LONG = (T_GAP_LONG_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int BURST_MAX = 16;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 8;
    localparam int CNT_W = 8;
    // Resource classes: plain, or carrying read side effects
    typedef enum logic [2:0] {
        HRCP_RES_PLAIN,
        HRCP_RES_RX_DATA,
        HRCP_RES_RX_STATUS,
        HRCP_RES_TX_STATUS,
        HRCP_RES_RX_FILL,
        HRCP_RES_TX_FILL,
        HRCP_RES_DISCARD,
        HRCP_RES_DP_CTRL
    } hrcp_res_type;
    typedef enum logic [1:0] {
        HRCP_IDLE,
        HRCP_WAIT,
        HRCP_STROBE,
        HRCP_RECOVER
    } hrcp_state_type;
endpackage : hrcp_pkg

// [test/hrcp_dev_model.sv]
// Behavioural model of the device read port
`timescale 1ns/1ps
module hrcp_dev_model #(
    parameter int LAT = 4
) (
    input wire logic i_clk,
    input wire logic i_chip_select_n,
    input wire logic i_read_strobe_n,
    input wire logic [7:0] i_addr,
    input wire logic i_queue_sel,
    output logic [15:0] o_data
);
    logic [15:0] last_q = 16'h0000;
    logic [7:0] addr_q = 8'h00;
    logic [3:0] age_q = 4'h0;
    logic [15:0] word;
    logic idle;
    assign idle = i_chip_select_n || i_read_strobe_n;
    assign word = i_queue_sel ? {8'hA5, 5'h00, i_addr[2:1], 1'b0} : {8'h00, i_addr};
    always_ff @(posedge i_clk) begin
        last_q <= o_data;
        addr_q <= i_addr;
        age_q <= (idle || addr_q != i_addr) ? 4'h0 : age_q + {3'h0, age_q != 4'hF};
    end
    // Released or settling bus shows a changing pattern
    assign o_data = (idle || age_q < LAT) ? ~last_q : word;
endmodule : hrcp_dev_model

// [test/hrcp_host_checker.sv]
// Pin timing checker of the host read cycle port
`timescale 1ns/1ps
module hrcp_host_checker #(
    parameter int DATA_W = 16,
    parameter int ADDR_W = 8
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic o_chip_select_n,
    input wire logic o_read_strobe_n,
    input wire logic [ADDR_W-1:0] o_addr,
    input wire logic o_queue_sel,
    input wire logic o_rd_valid,
    input wire logic i_rd_ready,
    input wire logic [DATA_W-1:0] o_rd_data
);
    logic [7:0] hi_q;
    logic [ADDR_W-1:0] base_q;
    logic [7:0] age_q;
    logic [ADDR_W-1:0] last_q;
    always_ff @(posedge i_clk) begin
        hi_q <= i_reset ? 8'hFF : (o_chip_select_n ? hi_q + {7'h00, hi_q != 8'hFF} : 8'h00);
        base_q <= o_chip_select_n ? o_addr : base_q;
        last_q <= o_addr;
        age_q <= (i_reset || o_addr != last_q) ? 8'h00 : age_q + {7'h00, age_q != 8'hFF};
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    sequence s_start; $fell(o_chip_select_n); endsequence
    sequence s_held; !o_chip_select_n && !$past(o_chip_select_n); endsequence
    property p_pair; o_chip_select_n == o_read_strobe_n; endproperty
    a_pair: assert property (p_pair) else $error("select and strobe differ");
    property p_low_min; s_start |-> !o_chip_select_n [*7]; endproperty
    a_low_min: assert property (p_low_min) else $error("strobe low too short");
    property p_setup; s_start |-> $stable(o_addr) && $stable(o_queue_sel); endproperty
    a_setup: assert property (p_setup) else $error("address moved at strobe");
    property p_qsel; s_held |-> $stable(o_queue_sel); endproperty
    a_qsel: assert property (p_qsel) else $error("queue select moved in cycle");
    property p_step; s_held and $changed(o_addr) |-> o_addr == $past(o_addr) + 1'b1; endproperty
    a_step: assert property (p_step) else $error("burst address step wrong");
    property p_acyc; s_held and $changed(o_addr) |-> age_q >= hrcp_pkg::CYC_ACYC - 1; endproperty
    a_acyc: assert property (p_acyc) else $error("burst address cycle too short");
    property p_burst; !o_chip_select_n |-> ADDR_W'(o_addr - base_q) < 16; endproperty
    a_burst: assert property (p_burst) else $error("burst longer than 16");
    property p_gap; s_start |-> hi_q >= hrcp_pkg::CYC_CYCLE - hrcp_pkg::CYC_CSL - 1; endproperty
    a_gap: assert property (p_gap) else $error("strobe high too short");
    property p_hold; o_rd_valid && !i_rd_ready |=> o_rd_valid && $stable(o_rd_data); endproperty
    a_hold: assert property (p_hold) else $error("read word dropped");
endmodule : hrcp_host_checker

// [test/hrcp_host_test.sv]
// Self-checking bench of the host read cycle port controller
`timescale 1ns/1ps
module hrcp_host_test;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic i_cmd_valid = 1'b0;
    logic i_rd_ready = 1'b1;
    logic i_cmd_queue_sel = 1'b0;
    logic i_cmd_after_skip = 1'b0;
    logic [7:0] i_cmd_addr = 8'h00;
    logic [4:0] i_cmd_len = 5'h00;
    hrcp_pkg::hrcp_res_type i_cmd_res = hrcp_pkg::HRCP_RES_PLAIN;
    logic o_cmd_ready, o_rd_valid, o_chip_select_n, o_read_strobe_n, o_queue_sel, stall, prev;
    logic [15:0] o_rd_data, i_data;
    logic [7:0] o_addr;
    logic [15:0] exp_q[$];
    int miscompares = 0;
    int total_checks = 0;
    int cyc = 0;
    int rise_cyc = 0;
    int gap = 0;
    initial forever #2.5 i_clk = ~i_clk;
    hrcp_host dut (.i_clk(i_clk), .i_reset(i_reset), .i_cmd_valid(i_cmd_valid), .o_cmd_ready(o_cmd_ready),
        .i_cmd_addr(i_cmd_addr), .i_cmd_len(i_cmd_len), .i_cmd_queue_sel(i_cmd_queue_sel), .i_cmd_res(i_cmd_res),
        .i_cmd_after_skip(i_cmd_after_skip), .o_rd_valid(o_rd_valid), .i_rd_ready(i_rd_ready),
        .o_rd_data(o_rd_data), .o_chip_select_n(o_chip_select_n), .o_read_strobe_n(o_read_strobe_n),
        .o_addr(o_addr), .o_queue_sel(o_queue_sel), .i_data(i_data));
    hrcp_dev_model #(.LAT(4)) dev (.i_clk(i_clk), .i_chip_select_n(o_chip_select_n),
        .i_read_strobe_n(o_read_strobe_n), .i_addr(o_addr), .i_queue_sel(o_queue_sel), .o_data(i_data));
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize
    task automatic wait_ready();
        int n;
        for (n = 0; n < 3000 && o_cmd_ready !== 1'b1; n++) @(posedge i_clk);
        if (n == 3000) begin
            miscompares++;
            summarize();
        end
    endtask : wait_ready
    task automatic issue(input logic [7:0] a, input int len, input logic q, input hrcp_pkg::hrcp_res_type r);
        int n;
        logic [7:0] ad;
        n = (len == 0) ? 1 : ((len > 16) ? 16 : len);
        for (int k = 0; k < n; k++) begin
            ad = a + k[7:0];
            exp_q.push_back(q ? {8'hA5, 5'h00, ad[2:1], 1'b0} : {8'h00, ad});
        end
        wait_ready();
        i_cmd_valid <= 1'b1;
        i_cmd_addr <= a;
        i_cmd_len <= 5'(len);
        i_cmd_queue_sel <= q;
        i_cmd_res <= r;
        i_cmd_after_skip <= (r == hrcp_pkg::HRCP_RES_RX_STATUS) || (r == hrcp_pkg::HRCP_RES_TX_STATUS);
        @(posedge i_clk);
        i_cmd_valid <= 1'b0;
        @(posedge i_clk);
        wait_ready();
    endtask : issue
    task automatic pair(input hrcp_pkg::hrcp_res_type a, input hrcp_pkg::hrcp_res_type b, input int need);
        issue(8'h10, 1, 1'b0, a);
        issue(8'h24, 1, 1'b0, b);
        check("spacing", 16'(gap >= need), 16'h0001);
    endtask : pair
    // ****************************************
    // Read word and strobe timing monitor
    // ****************************************
    always @(posedge i_clk) begin
        cyc++;
        if (prev === 1'b0 && o_chip_select_n === 1'b1) rise_cyc = cyc;
        if (prev === 1'b1 && o_chip_select_n === 1'b0) gap = cyc - rise_cyc;
        prev = o_chip_select_n;
        if (o_rd_valid === 1'b1 && i_rd_ready === 1'b1)
            check("word", o_rd_data, (exp_q.size() > 0) ? exp_q.pop_front() : ~o_rd_data);
        i_rd_ready <= !stall && ($urandom % 3 != 0);
    end
    initial begin
        void'($urandom(54));
        stall = 1'b0;
        repeat (16) @(posedge i_clk);
        i_reset <= 1'b0;
        @(posedge i_clk);
        issue(8'h00, 1, 1'b0, hrcp_pkg::HRCP_RES_PLAIN);
        issue(8'h30, 0, 1'b0, hrcp_pkg::HRCP_RES_PLAIN);
        stall = 1'b1;
        fork
            begin
                repeat (400) @(posedge i_clk);
                stall = 1'b0;
            end
        join_none
        issue(8'h40, 16, 1'b0, hrcp_pkg::HRCP_RES_PLAIN);
        issue(8'hFA, 20, 1'b0, hrcp_pkg::HRCP_RES_PLAIN);
        repeat (6) issue(8'($urandom), $urandom % 21, 1'($urandom), hrcp_pkg::HRCP_RES_RX_DATA);
        pair(hrcp_pkg::HRCP_RES_RX_DATA, hrcp_pkg::HRCP_RES_RX_FILL, hrcp_pkg::CYC_GAP_SHORT);
        pair(hrcp_pkg::HRCP_RES_RX_STATUS, hrcp_pkg::HRCP_RES_RX_FILL, hrcp_pkg::CYC_GAP_SHORT);
        pair(hrcp_pkg::HRCP_RES_TX_STATUS, hrcp_pkg::HRCP_RES_TX_FILL, hrcp_pkg::CYC_GAP_SHORT);
        pair(hrcp_pkg::HRCP_RES_DISCARD, hrcp_pkg::HRCP_RES_DISCARD, hrcp_pkg::CYC_GAP_LONG);
        pair(hrcp_pkg::HRCP_RES_DP_CTRL, hrcp_pkg::HRCP_RES_RX_STATUS, hrcp_pkg::CYC_GAP_LONG);
        pair(hrcp_pkg::HRCP_RES_DP_CTRL, hrcp_pkg::HRCP_RES_TX_STATUS, hrcp_pkg::CYC_GAP_LONG);
        pair(hrcp_pkg::HRCP_RES_PLAIN, hrcp_pkg::HRCP_RES_PLAIN, hrcp_pkg::CYC_CYCLE - hrcp_pkg::CYC_CSL);
        for (int n = 0; n < 500 && exp_q.size() > 0; n++) @(posedge i_clk);
        check("left", 16'(exp_q.size()), 16'h0000);
        summarize();
    end
endmodule : hrcp_host_test
bind hrcp_host hrcp_host_checker #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) chk (.i_clk(i_clk), .i_reset(i_reset),
    .o_chip_select_n(o_chip_select_n), .o_read_strobe_n(o_read_strobe_n), .o_addr(o_addr),
    .o_queue_sel(o_queue_sel), .o_rd_valid(o_rd_valid), .i_rd_ready(i_rd_ready), .o_rd_data(o_rd_data));
